/* File: design/ise_pkg.sv */
// Purpose: Constants for the interrupt source enable bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Printed offsets are word indices, byte address is index times four
package ise_pkg;
    localparam int ADDR_W = 12;
    localparam logic [9:0] EXT_EN_IDX = 10'h0D7;
    localparam logic [9:0] TMR_EN_IDX = 10'h0E7;
    localparam logic [11:0] EXT_EN_OFFS = {EXT_EN_IDX, 2'b00};
    localparam logic [11:0] TMR_EN_OFFS = {TMR_EN_IDX, 2'b00};
    localparam logic [11:0] GLOBAL_OFFS = 12'h100;
    localparam logic [11:0] STATUS_OFFS = 12'h104;
    localparam logic [11:0] MASK_OFFS = 12'h108;
    localparam int EXT_NUM = 6;
    localparam int TMR_NUM = 8;
    localparam int WDOG_POS = 0;
    localparam int WATCH_POS = 1;
    localparam int TBASE_POS = 2;
    localparam int PWM1_POS = 3;
    localparam int CAP1_POS = 6;
    localparam int GLOBAL_POS = 0;
    localparam logic [5:0] EXT_EN_RST = 6'h00;
    localparam logic [7:0] TMR_EN_RST = 8'h00;
    localparam logic [1:0] EXT_RSV_RST = 2'h0;
    localparam logic GLOBAL_RST = 1'b0;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
endpackage : ise_pkg

/* File: design/ise_source_enable.sv */
// Purpose: Per-source interrupt enable gate with APB register access
// Assumes: Request flags come from logic on sys_clk
// Notes: Status bit 0 = external group pass, bit 1 = timer group pass
//
// Operation
// - The external enable register holds enables 0 to 5, reset zero.
// - External enable bits 7 and 6 are reserved with no function.
// - Timer enable bit 0 gates the watchdog request, reset zero.
// - Timer enable bit 1 gates the watch timer request, reset zero.
// - Timer enable bit 2 gates the time-base request, reset zero.
// - Timer enable bits 3 to 5 gate PWM timers 1 to 3, reset zero.
// - Timer enable bits 6 and 7 gate capture timers 1 and 2.
// - Each source is masked alone, independent of its neighbours.
// - A cleared global enable blocks every request.
`timescale 1ns/1ps
`default_nettype none
module ise_source_enable (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] extReqFlag,
    input wire logic [7:0] tmrReqFlag,
    output logic [5:0] extReqPass,
    output logic [7:0] tmrReqPass,
    output logic irq
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [5:0] extEn_q;
    logic [1:0] extRsv_q;
    logic [7:0] tmrEn_q;
    logic globalEn_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [5:0] extPass_q;
    logic [7:0] tmrPass_q;
    logic irq_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction : hit

    // Exact match on the byte address: unaligned or unknown is unmapped

    // Access phase takes one wait state: answer comes with pready next edge
    wire logic access = psel && penable && !pready_q && clkEn;
    wire logic wrAcc = access && pwrite;
    wire logic selExt = hit(paddr, ise_pkg::EXT_EN_OFFS);
    wire logic selTmr = hit(paddr, ise_pkg::TMR_EN_OFFS);
    wire logic selGlb = hit(paddr, ise_pkg::GLOBAL_OFFS);
    wire logic selSts = hit(paddr, ise_pkg::STATUS_OFFS);
    wire logic selMsk = hit(paddr, ise_pkg::MASK_OFFS);
    wire logic mapped = selExt | selTmr | selGlb | selSts | selMsk;
    wire logic [31:0] rdMux =
        selExt ? {24'h000000, extRsv_q, extEn_q} :
        selTmr ? {24'h000000, tmrEn_q} :
        selGlb ? {31'h00000000, globalEn_q} :
        selSts ? {30'h00000000, status_q} :
        selMsk ? {30'h00000000, mask_q} : 32'h00000000;

    // ----------------------------------------
    // Request gating
    // ----------------------------------------
    // Per-source AND gates
    wire logic [5:0] extGate;
    wire logic [7:0] tmrGate;
    for (genvar i = 0; i < ise_pkg::EXT_NUM; i++) begin : g_ext
        assign extGate[i] = extReqFlag[i] & extEn_q[i];
    end
    for (genvar i = 0; i < ise_pkg::TMR_NUM; i++) begin : g_tmr
        assign tmrGate[i] = tmrReqFlag[i] & tmrEn_q[i];
    end
    wire logic [5:0] extPass_d = globalEn_q ? extGate : 6'h00;
    wire logic [7:0] tmrPass_d = globalEn_q ? tmrGate : 8'h00;
    wire logic [1:0] evt = {|tmrPass_d, |extPass_d};
    // Status and mask only feed irq; they never touch the enables
    // Set wins over a write-one clear in the same cycle
    wire logic [1:0] w1c = (wrAcc && selSts) ? pwdata[1:0] : 2'h0;
    wire logic [1:0] status_d = (status_q & ~w1c) | evt;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // External enables reset to zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            extEn_q <= ise_pkg::EXT_EN_RST;
            extRsv_q <= ise_pkg::EXT_RSV_RST;
        end else if (wrAcc && selExt) begin
            extEn_q <= pwdata[5:0];
            extRsv_q <= pwdata[7:6];
        end
    end

    // Watch timer enable in bit 1
    // PWM enables in bits 3 to 5
    // Capture enables in bits 6 and 7
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tmrEn_q <= ise_pkg::TMR_EN_RST;
        end else if (wrAcc && selTmr) begin
            tmrEn_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            globalEn_q <= ise_pkg::GLOBAL_RST;
            mask_q <= ise_pkg::MASK_RST;
        end else if (wrAcc) begin
            if (selGlb) begin
                globalEn_q <= pwdata[ise_pkg::GLOBAL_POS];
            end
            if (selMsk) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_q <= ise_pkg::STATUS_RST;
            extPass_q <= 6'h00;
            tmrPass_q <= 8'h00;
            irq_q <= 1'b0;
        end else if (clkEn) begin
            status_q <= status_d;
            extPass_q <= extPass_d;
            tmrPass_q <= tmrPass_d;
            // Next status, so a write-one clear drops irq one cycle sooner
            irq_q <= |(status_d & mask_q);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clkEn) begin
            pready_q <= access;
            pslverr_q <= access && !mapped;
            prdata_q <= (access && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign extReqPass = extPass_q;
    assign tmrReqPass = tmrPass_q;
    assign irq = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ext_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> extReqPass == ($past(extReqFlag) & $past(extEn_q)
            & {6{$past(globalEn_q)}}))
        else $error("external pass mismatch");

    a_rsv_nofunc: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && extRsv_q != $past(extRsv_q)) |=> extReqPass ==
            ($past(extReqFlag) & $past(extEn_q)
            & {6{$past(globalEn_q)}}))
        else $error("reserved bits affect gating");

    a_wdog_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && !tmrEn_q[ise_pkg::WDOG_POS])
            |=> !tmrReqPass[ise_pkg::WDOG_POS])
        else $error("watchdog passed while disabled");

    a_watch_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && globalEn_q && tmrEn_q[ise_pkg::WATCH_POS]
            && tmrReqFlag[ise_pkg::WATCH_POS])
            |=> tmrReqPass[ise_pkg::WATCH_POS])
        else $error("watch timer request lost");

    a_tbase_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && !tmrEn_q[ise_pkg::TBASE_POS])
            |=> !tmrReqPass[ise_pkg::TBASE_POS])
        else $error("time-base passed while disabled");

    a_pwm_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> tmrReqPass[5:3] == ($past(tmrReqFlag[5:3])
            & $past(tmrEn_q[5:3]) & {3{$past(globalEn_q)}}))
        else $error("pwm pass mismatch");

    a_cap_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> tmrReqPass[7:6] == ($past(tmrReqFlag[7:6])
            & $past(tmrEn_q[7:6]) & {2{$past(globalEn_q)}}))
        else $error("capture pass mismatch");

    a_global_block: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && !globalEn_q) |=> (extReqPass == 6'h00
            && tmrReqPass == 8'h00))
        else $error("request passed with global off");

    a_enable_stable: assert property (
        @(posedge sys_clk) disable iff (reset)
        !(wrAcc && (selExt || selTmr)) |=> $stable(tmrEn_q)
            && $stable(extEn_q))
        else $error("enable changed without write");

    a_bus_answer: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access && !mapped) |=> (pready && pslverr))
        else $error("unmapped access not flagged");

    a_source_indep: assert property (
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> tmrReqPass[2:0] == ($past(tmrReqFlag[2:0])
            & $past(tmrEn_q[2:0]) & {3{$past(globalEn_q)}}))
        else $error("single timer source pass mismatch");

    a_ext_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wrAcc && selExt) |=> extEn_q == $past(pwdata[5:0]))
        else $error("external enable write lost");

    a_tmr_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wrAcc && selTmr) |=> tmrEn_q == $past(pwdata[7:0]))
        else $error("timer enable write lost");

    a_global_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wrAcc && selGlb) |=> globalEn_q == $past(pwdata[0]))
        else $error("global enable write lost");

    a_clk_freeze: assert property (
        @(posedge sys_clk) disable iff (reset)
        !clkEn |=> $stable(extEn_q) && $stable(tmrEn_q)
            && $stable(globalEn_q) && $stable(status_q)
            && $stable(extReqPass) && $stable(tmrReqPass)
            && $stable(irq) && $stable(pready))
        else $error("state moved with clock enable low");

    a_status_set: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && globalEn_q && (extReqFlag & extEn_q) != 6'h00)
            |=> status_q[0])
        else $error("external event not recorded");

    a_status_clear: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wrAcc && selSts && pwdata[1] && !globalEn_q) |=> !status_q[1])
        else $error("timer status not cleared");

    a_irq_level: assert property (
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> irq == ((status_q & $past(mask_q)) != 2'h0))
        else $error("interrupt level mismatch");

    a_ready_pulse: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && pready) |=> !pready)
        else $error("ready held past one cycle");

    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access && !mapped && !pwrite) |=> prdata == 32'h00000000)
        else $error("unmapped read returned data");

    a_ext_dis: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && extEn_q == 6'h00) |=> extReqPass == 6'h00)
        else $error("external passed while all disabled");

    a_pwm_dis: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && tmrEn_q[5:3] == 3'h0) |=> tmrReqPass[5:3] == 3'h0)
        else $error("pwm passed while disabled");

    a_cap_dis: assert property (
        @(posedge sys_clk) disable iff (reset)
        (clkEn && tmrEn_q[7:6] == 2'h0) |=> tmrReqPass[7:6] == 2'h0)
        else $error("capture passed while disabled");
endmodule : ise_source_enable
`default_nettype wire

/* File: verif/ise_flag_src.sv */
// Purpose: Request flag sources facing the enable bank
// Assumes: Sources are peripheral logic on sys_clk
// Notes: One register stage, as a real flag would be
`timescale 1ns/1ps
`default_nettype none
module ise_flag_src (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [5:0] extSet,
    input wire logic [7:0] tmrSet,
    output logic [5:0] extFlag,
    output logic [7:0] tmrFlag
);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            extFlag <= 6'h00;
            tmrFlag <= 8'h00;
        end else begin
            extFlag <= extSet;
            tmrFlag <= tmrSet;
        end
    end
endmodule : ise_flag_src
`default_nettype wire

/* File: verif/interrupt_source_enable_bank_tb.sv */
// Purpose: Self-checking bench for the source enable bank
// Assumes: APB master changes signals on rising edges
// Notes: Reserved external bits are masked off before compare
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_enable_bank_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err;
    logic [5:0] extSet = 6'h00;
    logic [7:0] tmrSet = 8'h00;
    logic [5:0] extFlag, extReqPass;
    logic [7:0] tmrFlag, tmrReqPass;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    ise_source_enable u_dut (.sys_clk(sys_clk), .reset(reset),
        .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extReqFlag(extFlag),
        .tmrReqFlag(tmrFlag), .extReqPass(extReqPass),
        .tmrReqPass(tmrReqPass), .irq(irq));
    ise_flag_src u_src (.sys_clk(sys_clk), .reset(reset),
        .extSet(extSet), .tmrSet(tmrSet), .extFlag(extFlag),
        .tmrFlag(tmrFlag));
    // Pready, data and error taken at the rising edge, then released
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic t_reset;
        apb(1'b0, ise_pkg::EXT_EN_OFFS, 32'h0);
        chk(rd & 32'h3F, 32'h0);
        apb(1'b0, ise_pkg::TMR_EN_OFFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ise_pkg::GLOBAL_OFFS, 32'h0);
        chk(rd, 32'h0);
        $display("reset values done");
    endtask : t_reset
    task automatic t_rw;
        apb(1'b1, ise_pkg::TMR_EN_OFFS, 32'hA5);
        apb(1'b0, ise_pkg::TMR_EN_OFFS, 32'h0);
        chk(rd, 32'hA5);
        apb(1'b1, ise_pkg::EXT_EN_OFFS, 32'hEA);
        apb(1'b0, ise_pkg::EXT_EN_OFFS, 32'h0);
        chk(rd & 32'h3F, 32'h2A);
        $display("read back done");
    endtask : t_rw
    task automatic t_gate;
        extSet <= 6'h3F;
        tmrSet <= 8'hFF;
        apb(1'b1, ise_pkg::GLOBAL_OFFS, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ise_pkg::TMR_EN_OFFS, 32'h1 << i);
            apb(1'b1, ise_pkg::EXT_EN_OFFS, 32'h1 << (i % 6));
            @(negedge sys_clk);
            chk({26'h0, extReqPass}, 32'h1 << (i % 6));
            chk({24'h0, tmrReqPass}, 32'h1 << i);
        end
        apb(1'b0, ise_pkg::TMR_EN_OFFS, 32'h0);
        chk(rd, 32'h80);
        apb(1'b1, ise_pkg::EXT_EN_OFFS, 32'hC1);
        @(negedge sys_clk);
        chk({26'h0, extReqPass}, 32'h1);
        apb(1'b1, ise_pkg::GLOBAL_OFFS, 32'h0);
        @(negedge sys_clk);
        chk({18'h0, extReqPass, tmrReqPass}, 32'h0);
        $display("gating done");
    endtask : t_gate
    task automatic t_irq;
        apb(1'b0, ise_pkg::STATUS_OFFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, ise_pkg::MASK_OFFS, 32'h0);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ise_pkg::MASK_OFFS, 32'h2);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ise_pkg::STATUS_OFFS, 32'h3);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        // Clear while sources still pass: set must win
        apb(1'b1, ise_pkg::GLOBAL_OFFS, 32'h1);
        apb(1'b1, ise_pkg::STATUS_OFFS, 32'h3);
        apb(1'b0, ise_pkg::STATUS_OFFS, 32'h0);
        chk(rd, 32'h3);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ise_pkg::GLOBAL_OFFS, 32'h0);
        $display("interrupt done");
    endtask : t_irq
    task automatic t_err;
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("unmapped done");
    endtask : t_err
    task automatic t_midrst;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({17'h0, irq, extReqPass, tmrReqPass}, 32'h0);
        reset <= 1'b0;
        apb(1'b0, ise_pkg::TMR_EN_OFFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ise_pkg::EXT_EN_OFFS, 32'h0);
        chk(rd & 32'h3F, 32'h0);
        $display("mid-run reset done");
    endtask : t_midrst
    task automatic t_freeze;
        apb(1'b1, ise_pkg::GLOBAL_OFFS, 32'h1);
        apb(1'b1, ise_pkg::TMR_EN_OFFS, 32'h1);
        clkEn <= 1'b0;
        tmrSet <= 8'h00;
        repeat (3) @(posedge sys_clk);
        chk({24'h0, tmrReqPass}, 32'h1);
        clkEn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({24'h0, tmrReqPass}, 32'h0);
        $display("clock enable done");
    endtask : t_freeze
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_rw();
        t_gate();
        t_irq();
        t_err();
        t_midrst();
        t_freeze();
        test_done();
    end
endmodule : interrupt_source_enable_bank_tb
`default_nettype wire
